// ---- core/cns_nvm_ctrl.sv ----
// configuration register bank with non-volatile store and restore
// Notes on behaviour
// - power-up copies whole image into bank
// - settings come from volatile bank, not store
// - store copies bank words 0x01..0x1D
// - restore overwrites bank like power-up
// - restore trigger bit starts restore
// - idle flag low during restore, high after
// - both host ports trigger identically
// - store trigger bit starts store
// - store end sets idle flag, and success flag unless a failure was seen
// - trial store never writes the store
// - trial checks supply, reports like store
// - trial has own trigger, same status sequence
// - bank readable and writable over two-wire bus
// - target address 0x47, word address auto-increments
`timescale 1ns/1ps
`default_nettype none
module cns_nvm_ctrl #(
    parameter int          WORDS    = cns_pkg::BANK_WORDS,
    parameter logic [6:0]  DEV_ADDR = cns_pkg::TWI_TARGET
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // two-wire control bus
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    // production trimming register port
    input  wire logic               trim_wr,
    input  wire logic [7:0]         trim_addr,
    input  wire logic [7:0]         trim_wdata,
    output logic [7:0]              trim_rdata,
    // non-volatile array port
    output logic                    nvm_req,
    output logic                    nvm_we,
    output logic [4:0]              nvm_addr,
    output logic [7:0]              nvm_wdata,
    input  wire logic [7:0]         nvm_rdata,
    input  wire logic               nvm_ack,
    input  wire logic               nvm_fail,
    // supply monitor pin
    input  wire logic               supply_ok,
    // settings to the rest of the device
    output logic [WORDS*8-1:0]      cfg_bank,
    output logic                    cfg_valid
);
    logic [1:0]              rst_sync;
    logic                    rst_n;
    logic [7:0]              bank [WORDS];
    logic [2:0]              command;
    logic                    nvm_idle_flag;
    logic                    nvm_write_success;
    logic                    fail_seen;
    logic [1:0]              op_kind;
    logic [4:0]              idx;
    logic [2:0]              sup_s;
    logic                    sup_f;
    cns_pkg::cns_op_state_t  state;
    logic [7:0]              twi_addr;
    logic [7:0]              twi_wdata;
    logic                    twi_wr;
    logic [7:0]              twi_rdata;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // supply monitor sampled on three flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sup_s <= 3'h0;
            sup_f <= 1'b0;
        end
        else
        begin
            sup_s <= {sup_s[1:0], supply_ok};
            sup_f <= (sup_s[1] == sup_s[2]) ? sup_s[2] : sup_f;
        end
    end

    cns_twi_target #(
        .DEV_ADDR (DEV_ADDR)
    ) u_twi (
        .clk       (clk),
        .rst_n     (rst_n),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .sda_out   (sda_out),
        .sda_oe    (sda_oe),
        .reg_addr  (twi_addr),
        .reg_wdata (twi_wdata),
        .reg_wr    (twi_wr),
        .reg_rdata (twi_rdata)
    );

    // host write merge; two-wire bus wins a same-cycle collision
    wire        host_wr    = twi_wr | trim_wr;
    wire [7:0]  host_addr  = twi_wr ? twi_addr : trim_addr;
    wire [7:0]  host_wdata = twi_wr ? twi_wdata : trim_wdata;
    wire        idle_now   = nvm_idle_flag & (state == cns_pkg::ST_IDLE);
    wire        bank_wr    = host_wr & idle_now & (host_addr <= cns_pkg::ADDR_BANK_LAST);
    wire        cmd_wr     = host_wr & idle_now & (host_addr == cns_pkg::ADDR_COMMAND);
    wire        load_word  = (state == cns_pkg::ST_XFER) & (op_kind == cns_pkg::OP_RESTORE)
                             & nvm_ack;
    wire        trial_step = (state == cns_pkg::ST_XFER) & (op_kind == cns_pkg::OP_TRIAL);
    wire        word_done  = trial_step | ((state == cns_pkg::ST_XFER) & nvm_ack);
    wire        last_word  = (idx == cns_pkg::IMAGE_LAST);

    // read view: status bits overlay the top of word 0x01
    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a <= cns_pkg::ADDR_BANK_LAST)
            v = bank[a[4:0]];
        if (a == cns_pkg::ADDR_STATUS)
        begin
            v[cns_pkg::STAT_IDLE_BIT] = nvm_idle_flag;
            v[cns_pkg::STAT_OK_BIT]   = nvm_write_success;
        end
        if (a == cns_pkg::ADDR_COMMAND)
            v = {5'h00, command};
        return v;
    endfunction : read_reg

    // process form so bank and status changes reach the bus without an address change
    always_comb
        twi_rdata = read_reg(twi_addr);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            trim_rdata <= 8'h00;
        else
            trim_rdata <= read_reg(trim_addr);
    end

    // bank words: host write or restore load
    genvar g;
    generate
        for (g = 0; g < WORDS; g++)
        begin : g_bank
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    bank[g] <= cns_pkg::BANK_RESET;
                else if (load_word && idx == 5'(g))
                    bank[g] <= nvm_rdata;
                else if (bank_wr && host_addr[4:0] == 5'(g))
                    bank[g] <= host_wdata;
            end
            assign cfg_bank[g*8 +: 8] = bank[g];
        end
    endgenerate

    assign nvm_req   = (state == cns_pkg::ST_XFER) & (op_kind != cns_pkg::OP_TRIAL);
    assign nvm_we    = (op_kind == cns_pkg::OP_STORE);
    assign nvm_addr  = idx;
    assign nvm_wdata = bank[idx];

    // sequencer; reset state runs the power-up restore
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state             <= cns_pkg::ST_XFER;
            op_kind           <= cns_pkg::OP_RESTORE;
            idx               <= cns_pkg::RESTORE_FIRST;
            nvm_idle_flag     <= 1'b0;
            nvm_write_success <= 1'b0;
            fail_seen         <= 1'b0;
            command           <= cns_pkg::COMMAND_RESET;
            cfg_valid         <= 1'b0;
        end
        else
        begin
            if (cmd_wr)
                command <= command | host_wdata[2:0];
            case (state)
                cns_pkg::ST_IDLE:
                    if (command != 3'h0)
                    begin
                        nvm_idle_flag <= 1'b0;
                        fail_seen     <= 1'b0;
                        state         <= cns_pkg::ST_XFER;
                        if (command[cns_pkg::OP_RESTORE])
                        begin
                            op_kind <= cns_pkg::OP_RESTORE;
                            idx     <= cns_pkg::RESTORE_FIRST;
                        end
                        else
                        begin
                            op_kind <= command[cns_pkg::OP_STORE] ? cns_pkg::OP_STORE
                                                                  : cns_pkg::OP_TRIAL;
                            idx     <= cns_pkg::STORE_FIRST;
                        end
                    end
                cns_pkg::ST_XFER:
                    if (word_done)
                    begin
                        if (!sup_f || (nvm_ack && nvm_fail))
                            fail_seen <= 1'b1;
                        if (last_word)
                            state <= cns_pkg::ST_DONE;
                        else
                            idx <= idx + 5'h01;
                    end
                cns_pkg::ST_DONE:
                begin
                    command[op_kind] <= 1'b0;
                    nvm_idle_flag    <= 1'b1;
                    cfg_valid        <= 1'b1;
                    if (op_kind != cns_pkg::OP_RESTORE)
                        nvm_write_success <= ~fail_seen;
                    state <= cns_pkg::ST_IDLE;
                end
                default:
                    state <= cns_pkg::ST_IDLE;
            endcase
        end
    end
endmodule : cns_nvm_ctrl
`default_nettype wire

// ---- core/cns_twi_target.sv ----
// two-wire bus target with auto-incrementing word address
`timescale 1ns/1ps
`default_nettype none
module cns_twi_target #(
    parameter logic [6:0] DEV_ADDR = cns_pkg::TWI_TARGET
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // register side
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    input  wire logic [7:0] reg_rdata
);
    logic [2:0]               scl_s;
    logic [2:0]               sda_s;
    logic                     scl_f;
    logic                     sda_f;
    logic                     scl_p;
    logic                     sda_p;
    logic [3:0]               bit_cnt;
    logic [7:0]               shreg;
    logic                     drive_low;
    logic                     rd_dir;
    logic                     master_ack;
    cns_pkg::cns_twi_state_t  state;

    wire rise      = scl_f & ~scl_p;
    wire fall      = ~scl_f & scl_p;
    wire start_det = scl_f & scl_p & sda_p & ~sda_f;
    wire stop_det  = scl_f & scl_p & ~sda_p & sda_f;
    wire byte_end  = fall & (bit_cnt == 4'h8);
    wire dev_hit   = (shreg[7:1] == DEV_ADDR);

    assign sda_out = 1'b0;
    assign sda_oe  = drive_low;

    // three-stage pin sampling, level taken once stages two and three agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end
        else
        begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            scl_f <= (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
            sda_f <= (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= cns_pkg::TW_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            drive_low  <= 1'b0;
            rd_dir     <= 1'b0;
            master_ack <= 1'b0;
            reg_addr   <= 8'h00;
            reg_wdata  <= 8'h00;
            reg_wr     <= 1'b0;
        end
        else
        begin
            reg_wr <= 1'b0;
            if (start_det)
            begin
                state     <= cns_pkg::TW_DEV;
                bit_cnt   <= 4'h0;
                drive_low <= 1'b0;
            end
            else if (stop_det)
            begin
                state     <= cns_pkg::TW_IDLE;
                drive_low <= 1'b0;
            end
            else
            begin
                if (rise && (state == cns_pkg::TW_DEV || state == cns_pkg::TW_WA
                             || state == cns_pkg::TW_WR))
                begin
                    shreg   <= {shreg[6:0], sda_f};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                if (rise && state == cns_pkg::TW_RD)
                    bit_cnt <= bit_cnt + 4'h1;
                if (rise && state == cns_pkg::TW_RD_ACK)
                    master_ack <= ~sda_f;
                case (state)
                    cns_pkg::TW_DEV:
                        if (byte_end)
                        begin
                            state     <= dev_hit ? cns_pkg::TW_DEV_ACK : cns_pkg::TW_IDLE;
                            drive_low <= dev_hit;
                            rd_dir    <= shreg[0];
                        end
                    cns_pkg::TW_DEV_ACK, cns_pkg::TW_RD_ACK:
                        if (fall)
                        begin
                            bit_cnt <= 4'h0;
                            if (rd_dir && (state == cns_pkg::TW_DEV_ACK || master_ack))
                            begin
                                shreg     <= reg_rdata;
                                drive_low <= ~reg_rdata[7];
                                reg_addr  <= reg_addr + 8'h01;
                                state     <= cns_pkg::TW_RD;
                            end
                            else
                            begin
                                drive_low <= 1'b0;
                                state     <= rd_dir ? cns_pkg::TW_IDLE : cns_pkg::TW_WA;
                            end
                        end
                    cns_pkg::TW_WA:
                        if (byte_end)
                        begin
                            reg_addr  <= shreg;
                            drive_low <= 1'b1;
                            state     <= cns_pkg::TW_WA_ACK;
                        end
                    cns_pkg::TW_WR:
                        if (byte_end)
                        begin
                            reg_wdata <= shreg;
                            reg_wr    <= 1'b1;
                            drive_low <= 1'b1;
                            state     <= cns_pkg::TW_WR_ACK;
                        end
                    cns_pkg::TW_WA_ACK, cns_pkg::TW_WR_ACK:
                        if (fall)
                        begin
                            if (state == cns_pkg::TW_WR_ACK)
                                reg_addr <= reg_addr + 8'h01;
                            drive_low <= 1'b0;
                            bit_cnt   <= 4'h0;
                            state     <= cns_pkg::TW_WR;
                        end
                    cns_pkg::TW_RD:
                        if (fall)
                        begin
                            if (bit_cnt == 4'h8)
                            begin
                                drive_low <= 1'b0;
                                state     <= cns_pkg::TW_RD_ACK;
                            end
                            else
                            begin
                                shreg     <= {shreg[6:0], 1'b0};
                                drive_low <= ~shreg[6];
                            end
                        end
                    default: ;
                endcase
            end
        end
    end
endmodule : cns_twi_target
`default_nettype wire

// ---- include/cns_pkg.sv ----
// constants for the configuration store / restore block
package cns_pkg;
    localparam int          BANK_WORDS     = 30;
    localparam logic [7:0]  ADDR_BANK_LAST = 8'h1D;
    localparam logic [7:0]  ADDR_STATUS    = 8'h01;
    localparam logic [7:0]  ADDR_COMMAND   = 8'h34;
    localparam logic [4:0]  RESTORE_FIRST  = 5'h00;
    localparam logic [4:0]  STORE_FIRST    = 5'h01;
    localparam logic [4:0]  IMAGE_LAST     = 5'h1D;
    localparam int          STAT_IDLE_BIT  = 7;
    localparam int          STAT_OK_BIT    = 6;
    localparam logic [7:0]  BANK_RESET     = 8'h00;
    localparam logic [2:0]  COMMAND_RESET  = 3'h0;
    localparam logic [1:0]  OP_RESTORE     = 2'h0;
    localparam logic [1:0]  OP_STORE       = 2'h1;
    localparam logic [1:0]  OP_TRIAL       = 2'h2;
    localparam logic [6:0]  TWI_TARGET     = 7'h47;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XFER,
        ST_DONE
    } cns_op_state_t;

    typedef enum logic [3:0] {
        TW_IDLE,
        TW_DEV,
        TW_DEV_ACK,
        TW_WA,
        TW_WA_ACK,
        TW_WR,
        TW_WR_ACK,
        TW_RD,
        TW_RD_ACK
    } cns_twi_state_t;
endpackage : cns_pkg

// ---- test/cns_nvm_array.sv ----
// behavioural non-volatile array answering word requests
`timescale 1ns/1ps
`default_nettype none
module cns_nvm_array (
    // clock
    input  wire logic       clk,
    // word port
    input  wire logic       req,
    input  wire logic       we,
    input  wire logic [4:0] addr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata,
    output logic            ack,
    output logic            fail,
    // scenario controls
    input  wire logic       slow,
    input  wire logic       bad
);
    logic [7:0] mem [30];
    logic [2:0] wait_cnt;
    initial
    begin
        for (int i = 0; i < 30; i++)
            mem[i] = 8'h30 + 8'(i);
        ack = 1'b0;
        wait_cnt = 3'h0;
    end
    // data is only good while acking
    assign rdata = ack ? mem[addr] : ~mem[addr];
    assign fail  = ack & bad;
    always @(posedge clk)
    begin
        if (!req || ack)
        begin
            ack <= 1'b0;
            wait_cnt <= 3'h0;
        end
        else if (wait_cnt == (slow ? 3'h4 : 3'h0))
        begin
            ack <= 1'b1;
            if (we && !bad)
                mem[addr] <= wdata;
        end
        else
            wait_cnt <= wait_cnt + 3'h1;
    end
endmodule : cns_nvm_array
`default_nettype wire

// ---- test/cns_nvm_ctrl_monitor.sv ----
// concurrent checks on the store / restore block ports
`timescale 1ns/1ps
`default_nettype none
module cns_nvm_ctrl_monitor #(
    parameter int WORDS = cns_pkg::BANK_WORDS
) (
    // clock and reset
    input wire logic             clk,
    input wire logic             rst_b,
    // two-wire bus
    input wire logic             scl_in,
    input wire logic             sda_in,
    input wire logic             sda_out,
    input wire logic             sda_oe,
    // trimming port
    input wire logic             trim_wr,
    input wire logic [7:0]       trim_addr,
    input wire logic [7:0]       trim_wdata,
    input wire logic [7:0]       trim_rdata,
    // array port
    input wire logic             nvm_req,
    input wire logic             nvm_we,
    input wire logic [4:0]       nvm_addr,
    input wire logic [7:0]       nvm_wdata,
    input wire logic [7:0]       nvm_rdata,
    input wire logic             nvm_ack,
    input wire logic             nvm_fail,
    // supply and settings
    input wire logic             supply_ok,
    input wire logic [WORDS*8-1:0] cfg_bank,
    input wire logic             cfg_valid
);
    // copy of the block's reset release, one stage later for margin
    logic [2:0] rel;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rel <= 3'h0;
        else
            rel <= {rel[1:0], 1'b1};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rel[2]);

    sda_idle_a: assert property (sda_out == 1'b0)
        else $error("data pin output not zero");
    oe_clock_low_a: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pin pulled while bus clock high");
    req_hold_a: assert property (nvm_req && !nvm_ack |=> nvm_req && $stable(nvm_addr)
        && $stable(nvm_we) && $stable(nvm_wdata)) else $error("array request dropped");
    addr_step_a: assert property (nvm_req && nvm_ack && nvm_addr != 5'h1D
        |=> nvm_req && nvm_addr == $past(nvm_addr) + 5'h01) else $error("word skipped");
    addr_range_a: assert property (nvm_req |-> nvm_addr <= 5'h1D)
        else $error("word index beyond image");
    op_start_a: assert property ($rose(nvm_req) |-> nvm_addr == (nvm_we ? 5'h01 : 5'h00))
        else $error("operation starts at wrong word");
    op_end_a: assert property (nvm_req && nvm_ack && nvm_addr == 5'h1D
        |-> ##[1:2] !nvm_req) else $error("request not released after last word");
    valid_hold_a: assert property (cfg_valid |=> cfg_valid)
        else $error("settings valid dropped");
    bank_hold_a: assert property (!trim_wr && !sda_oe && !(nvm_req && nvm_ack && !nvm_we)
        |=> $stable(cfg_bank)) else $error("bank changed without cause");
    trim_read_a: assert property (trim_addr <= 8'h1D && trim_addr != 8'h01
        |=> trim_rdata == $past(cfg_bank[8*int'(trim_addr) +: 8]))
        else $error("trim read data wrong");
    cmd_read_a: assert property (trim_addr == 8'h34 |=> trim_rdata[7:3] == 5'h00)
        else $error("command upper bits not zero");
endmodule : cns_nvm_ctrl_monitor

bind cns_nvm_ctrl cns_nvm_ctrl_monitor #(.WORDS(WORDS)) u_cns_nvm_ctrl_monitor (
    .clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .trim_wr(trim_wr), .trim_addr(trim_addr), .trim_wdata(trim_wdata),
    .trim_rdata(trim_rdata), .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack), .nvm_fail(nvm_fail),
    .supply_ok(supply_ok), .cfg_bank(cfg_bank), .cfg_valid(cfg_valid));
`default_nettype wire

// ---- test/config_nvm_store_restore_test.sv ----
// self-checking bench for the configuration store / restore block
`timescale 1ns/1ps
`default_nettype none
module config_nvm_store_restore_test;
    logic       clk, rst_b, trim_wr, supply_ok, slow, bad;
    logic [7:0] trim_addr, trim_wdata, trim_rdata, nvm_rdata, nvm_wdata, v;
    logic       sda_out, sda_oe, nvm_req, nvm_we, nvm_ack, nvm_fail, cfg_valid;
    logic       scl, sda;
    wire        sda_line = sda & ~sda_oe;
    logic [4:0] nvm_addr;
    logic [cns_pkg::BANK_WORDS*8-1:0] cfg_bank;
    logic [7:0] exp_mem [30];
    logic [7:0] exp_bank [30];
    int         error_cnt = 0;
    int         n_compared = 0;
    int         cycles = 0;

    cns_nvm_ctrl u_cns_nvm_ctrl (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .trim_wr(trim_wr), .trim_addr(trim_addr),
        .trim_wdata(trim_wdata), .trim_rdata(trim_rdata), .nvm_req(nvm_req),
        .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
        .nvm_ack(nvm_ack), .nvm_fail(nvm_fail), .supply_ok(supply_ok),
        .cfg_bank(cfg_bank), .cfg_valid(cfg_valid));
    cns_nvm_array u_cns_nvm_array (.clk(clk), .req(nvm_req), .we(nvm_we), .addr(nvm_addr),
        .wdata(nvm_wdata), .rdata(nvm_rdata), .ack(nvm_ack), .fail(nvm_fail),
        .slow(slow), .bad(bad));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp8

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        trim_addr = a;
        trim_wdata = d;
        trim_wr = 1'b1;
        @(negedge clk);
        trim_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        trim_addr = a;
        @(negedge clk);
        d = trim_rdata;
    endtask : rd

    // poll status until idle, bounded
    task automatic finish_op();
        int n;
        n = 0;
        v = 8'h00;
        while (v[7] !== 1'b1 && n < 400)
        begin
            rd(8'h01, v);
            n++;
        end
        cmp8({7'h0, v[7]}, 8'h01);
        cmd_clear();
        rd(8'h01, v);
    endtask : finish_op

    task automatic start_op(input logic [7:0] bits);
        logic [7:0] s;
        wr(8'h34, bits);
        repeat (2) @(negedge clk);
        rd(8'h01, s);
        cmp8({7'h0, s[7]}, 8'h00);
    endtask : start_op

    task automatic cmd_clear();
        logic [7:0] c;
        rd(8'h34, c);
        cmp8(c, 8'h00);
    endtask : cmd_clear

    task automatic check_bank();
        for (int i = 0; i < 30; i++)
            cmp8(cfg_bank[i*8 +: 8], exp_bank[i]);
    endtask : check_bank

    task automatic t_powerup();
        finish_op();
        for (int i = 0; i < 30; i++)
        begin
            exp_mem[i] = 8'h30 + 8'(i);
            exp_bank[i] = exp_mem[i];
        end
        check_bank();
        cmp8({7'h0, cfg_valid}, 8'h01);
        $display("done powerup");
    endtask : t_powerup

    task automatic t_store_fail();
        bad = 1'b1;
        start_op(8'h02);
        finish_op();
        cmp8({7'h0, v[6]}, 8'h00);
        cmd_clear();
        bad = 1'b0;
        $display("done store fail");
    endtask : t_store_fail

    task automatic t_store();
        for (int i = 0; i < 30; i++)
        begin
            exp_bank[i] = 8'hA0 ^ 8'(i);
            wr(8'(i), exp_bank[i]);
        end
        for (int i = 1; i < 30; i++)
            exp_mem[i] = exp_bank[i];
        start_op(8'h04);
        finish_op();
        cmp8({7'h0, v[6]}, 8'h01);
        slow = 1'b1;
        start_op(8'h02);
        wr(8'h05, 8'hFF);
        wr(8'h34, 8'h01);
        finish_op();
        cmp8({7'h0, v[6]}, 8'h01);
        cmd_clear();
        check_bank();
        slow = 1'b0;
        $display("done store");
    endtask : t_store

    task automatic t_trial();
        wr(8'h03, 8'h11);
        exp_bank[3] = 8'h11;
        supply_ok = 1'b0;
        start_op(8'h04);
        finish_op();
        cmp8({7'h0, v[6]}, 8'h00);
        supply_ok = 1'b1;
        // let the supply sampler settle before the next trial
        repeat (4) @(negedge clk);
        start_op(8'h04);
        finish_op();
        cmp8({7'h0, v[6]}, 8'h01);
        cmd_clear();
        check_bank();
        $display("done trial");
    endtask : t_trial

    task automatic t_restore();
        start_op(8'h01);
        finish_op();
        cmp8({7'h0, v[6]}, 8'h01);
        cmd_clear();
        for (int i = 0; i < 30; i++)
            exp_bank[i] = exp_mem[i];
        check_bank();
        $display("done restore");
    endtask : t_restore

    // one bus bit: data set while clock low, line taken while clock high
    task automatic tw_bit(input logic b, output logic s);
        sda = b;
        repeat (4) @(negedge clk);
        scl = 1'b1;
        repeat (4) @(negedge clk);
        s = sda_line;
        scl = 1'b0;
        repeat (4) @(negedge clk);
    endtask : tw_bit

    // two-wire write of two bytes from word 0x07, read back over trim port
    task automatic t_twi();
        logic [35:0] bits;
        logic        s;
        bits = {cns_pkg::TWI_TARGET, 1'b0, 1'b1, 8'h07, 1'b1, 8'h5A, 1'b1, 8'hC3, 1'b1};
        sda = 1'b0;
        repeat (4) @(negedge clk);
        scl = 1'b0;
        for (int i = 35; i >= 0; i--)
        begin
            tw_bit(bits[i], s);
            if (i % 9 == 0)
                cmp8({7'h0, s}, 8'h00);
        end
        sda = 1'b0;
        repeat (4) @(negedge clk);
        scl = 1'b1;
        repeat (4) @(negedge clk);
        sda = 1'b1;
        repeat (4) @(negedge clk);
        rd(8'h07, v);
        cmp8(v, 8'h5A);
        rd(8'h08, v);
        cmp8(v, 8'hC3);
        $display("done two-wire");
    endtask : t_twi

    initial
    begin
        rst_b = 1'b0;
        trim_wr = 1'b0;
        trim_addr = 8'h00;
        trim_wdata = 8'h00;
        supply_ok = 1'b1;
        slow = 1'b0;
        bad = 1'b0;
        scl = 1'b1;
        sda = 1'b1;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_powerup();
        t_store_fail();
        t_store();
        t_trial();
        t_restore();
        t_twi();
        report_and_stop();
    end
endmodule : config_nvm_store_restore_test
`default_nettype wire
